// ==== inc/npc_pkg.sv ====
package npc_pkg;

  // =====================================================
  // Commands
  localparam logic [7:0] CMD_READ_FIRST = 8'h00;
  localparam logic [7:0] CMD_READ_SECOND = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR = 8'h00;

  // =====================================================
  // Page geometry and status layout
  localparam logic [9:0] COL_MAIN_LAST = 10'h1FF;
  localparam logic [9:0] COL_SPARE_FIRST = 10'h200;
  localparam logic [9:0] COL_SPARE_LAST = 10'h20F;
  localparam logic [9:0] COL_HALF = 10'h100;
  localparam int STATUS_FAIL_BIT = 0;
  localparam int STATUS_SUSPEND_BIT = 5;
  localparam int STATUS_READY_BIT = 6;
  localparam int STATUS_WP_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  localparam int MAX_PARTIAL_PROGRAMS = 10;

  // =====================================================
  // Timing, clock period 10 ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_LOW_NS = 40;
  localparam int STROBE_HIGH_NS = 20;
  localparam int WE_TO_RE_NS = 60;
  localparam int WE_TO_BUSY_NS = 100;
  localparam logic [3:0] LOW_CYC = 4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HIGH_CYC = 4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WHR_CYC = 4'((WE_TO_RE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WB_CYC = 4'((WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // =====================================================
  // Types
  typedef enum logic [3:0] {
    OP_READ_MAIN = 4'h0,
    OP_READ_SPARE = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_ERASE = 4'h3,
    OP_STATUS = 4'h4,
    OP_READ_ID = 4'h5,
    OP_RESET = 4'h6,
    OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8
  } npc_op_t;

  typedef enum logic [2:0] {
    K_CMD = 3'h0,
    K_ADDR = 3'h1,
    K_WDATA = 3'h2,
    K_READ = 3'h3,
    K_WAIT = 3'h4
  } npc_kind_t;

endpackage

// ==== verilog/npc_pin_cycle.sv ====
`timescale 1ns/1ps
module npc_pin_cycle
  import npc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Cycle request
  input wire logic cycStart,
  input npc_kind_t cycKind,
  input wire logic [7:0] cycByte,
  output logic cycDone,
  output logic [7:0] cycData,
  // Flash pins
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOeN,
  output logic cmdLatch,
  output logic addrLatch,
  output logic writeStrobeN,
  output logic readStrobeN,
  input wire logic readyBusyN
);

  typedef enum logic [4:0] {
    E_IDLE = 5'b00001,
    E_SETUP = 5'b00010,
    E_LOW = 5'b00100,
    E_HIGH = 5'b01000,
    E_RB = 5'b10000
  } npc_eng_t;

  npc_eng_t state;
  npc_kind_t kind;
  logic [3:0] cnt;

  // =====================================================
  // Pin decode
  wire isRead = (kind == K_READ);
  wire isWait = (kind == K_WAIT);
  wire inStrobe = (state == E_LOW) || (state == E_HIGH);
  wire cntEnd = (cnt == 4'h1);

  assign writeStrobeN = !((state == E_LOW) && !isRead && !isWait);
  assign readStrobeN = !((state == E_LOW) && isRead);
  assign ioOeN = !(inStrobe && !isRead && !isWait);
  assign cmdLatch = inStrobe && (kind == K_CMD);
  assign addrLatch = inStrobe && (kind == K_ADDR);

  // =====================================================
  // Cycle sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= E_IDLE;
      kind <= K_CMD;
      cnt <= 4'h0;
      ioOut <= 8'h00;
      cycData <= 8'h00;
      cycDone <= 1'b0;
    end else begin
      cycDone <= 1'b0;
      case (state)
        E_IDLE: begin
          if (cycStart) begin
            kind <= cycKind;
            ioOut <= cycByte;
            if (cycKind == K_READ) begin
              state <= E_SETUP;
              cnt <= WHR_CYC;
            end else if (cycKind == K_WAIT) begin
              state <= E_SETUP;
              cnt <= WB_CYC;
            end else begin
              state <= E_LOW;
              cnt <= LOW_CYC;
            end
          end
        end
        E_SETUP: begin
          // Ready/busy only trusted after the busy delay has passed
          cnt <= cnt - 4'h1;
          if (cntEnd) begin
            state <= isWait ? E_RB : E_LOW;
            cnt <= LOW_CYC;
          end
        end
        E_LOW: begin
          cnt <= cnt - 4'h1;
          if (cntEnd) begin
            if (isRead) begin
              cycData <= ioIn;
            end
            state <= E_HIGH;
            cnt <= HIGH_CYC;
          end
        end
        E_HIGH: begin
          cnt <= cnt - 4'h1;
          if (cntEnd) begin
            state <= E_IDLE;
            cycDone <= 1'b1;
          end
        end
        E_RB: begin
          if (readyBusyN) begin
            state <= E_IDLE;
            cycDone <= 1'b1;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end

endmodule

// ==== verilog/npc_host.sv ====
`timescale 1ns/1ps
module npc_host
  import npc_pkg::*;
#(
  parameter int LEN_W = 10,
  parameter int MAX_PARTIAL = MAX_PARTIAL_PROGRAMS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operation request
  input wire logic opValid,
  output logic opReady,
  input npc_op_t opCode,
  input wire logic [21:0] opAddr,
  input wire logic [LEN_W-1:0] opLen,
  input wire logic spareEn,
  output logic opDone,
  output logic opRefused,
  output logic [7:0] opStatus,
  output logic opFail,
  // Write data
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  // Read data
  output logic [7:0] rdData,
  output logic rdValid,
  // Flash pins
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOeN,
  output logic cmdLatch,
  output logic addrLatch,
  output logic chipEnableN,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic spareEnableN,
  output logic writeProtectN,
  input wire logic readyBusyN
);

  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_CMD = 10'b0000000010,
    S_ADDR = 10'b0000000100,
    S_WDATA = 10'b0000001000,
    S_CONF = 10'b0000010000,
    S_WAIT = 10'b0000100000,
    S_RDATA = 10'b0001000000,
    S_SCMD = 10'b0010000000,
    S_SREAD = 10'b0100000000,
    S_DONE = 10'b1000000000
  } npc_state_t;

  npc_state_t state;
  npc_op_t op;
  logic [21:0] addr;
  logic [LEN_W-1:0] len;
  logic [1:0] addrIdx;
  logic [9:0] col;
  logic pend;
  logic [12:0] progPage;
  logic [3:0] progCount;
  logic cycDone;
  logic [7:0] cycData;
  npc_kind_t cycKind;
  logic [7:0] cycByte;

  // =====================================================
  // Command and address selection
  function automatic logic [7:0] first_cmd(input npc_op_t o, input logic half);
    case (o)
      OP_READ_MAIN: first_cmd = half ? CMD_READ_SECOND : CMD_READ_FIRST;
      OP_READ_SPARE: first_cmd = CMD_READ_SPARE;
      OP_PROGRAM: first_cmd = CMD_PROG_SETUP;
      OP_ERASE: first_cmd = CMD_ERASE_SETUP;
      OP_STATUS: first_cmd = CMD_STATUS;
      OP_READ_ID: first_cmd = CMD_READ_ID;
      OP_SUSPEND: first_cmd = CMD_ERASE_SUSPEND;
      OP_RESUME: first_cmd = CMD_ERASE_RESUME;
      default: first_cmd = CMD_RESET;
    endcase
  endfunction

  wire isRead = (op == OP_READ_MAIN) || (op == OP_READ_SPARE);
  wire isSpare = (op == OP_READ_SPARE);
  wire [1:0] addrLast = (op == OP_READ_ID) ? 2'd0 : 2'd2;
  // Erase skips the column byte and sends only the two row bytes
  wire [1:0] addrStart = (op == OP_ERASE) ? 2'd1 : 2'd0;
  wire [7:0] colByte = isSpare ? {4'h0, addr[3:0]} : addr[7:0];
  wire [7:0] addrByte = (op == OP_READ_ID) ? ID_ADDR :
    (addrIdx == 2'd0) ? colByte :
    (addrIdx == 2'd1) ? addr[16:9] : {3'h0, addr[21:17]};
  wire [9:0] startCol = isSpare ? (COL_SPARE_FIRST | {6'h0, addr[3:0]}) :
    ({2'h0, addr[7:0]} | (addr[8] ? COL_HALF : 10'h000));
  // Registered spare enable, so a late change on the request port cannot move the page end
  wire [9:0] lastCol = (isSpare || !spareEnableN) ? COL_SPARE_LAST : COL_MAIN_LAST;
  // Next page restarts at the first half, or at the spare area
  wire [9:0] wrapCol = isSpare ? COL_SPARE_FIRST : 10'h000;
  wire samePage = (opAddr[21:9] == progPage);
  wire overLimit = (opCode == OP_PROGRAM) && samePage && (progCount == 4'(MAX_PARTIAL));
  wire issueState = (state == S_CMD) || (state == S_ADDR) || (state == S_CONF) ||
    (state == S_WAIT) || (state == S_RDATA) || (state == S_SCMD) || (state == S_SREAD) ||
    ((state == S_WDATA) && wrValid);
  wire cycStart = issueState && !pend;

  always_comb begin
    cycKind = K_CMD;
    cycByte = first_cmd(op, addr[8]);
    case (state)
      S_ADDR: begin
        cycKind = K_ADDR;
        cycByte = addrByte;
      end
      S_WDATA: begin
        cycKind = K_WDATA;
        cycByte = wrData;
      end
      S_CONF: cycByte = (op == OP_ERASE) ? CMD_ERASE_CONFIRM : CMD_PROG_CONFIRM;
      S_WAIT: cycKind = K_WAIT;
      S_SCMD: cycByte = CMD_STATUS;
      S_RDATA, S_SREAD: cycKind = K_READ;
      default: cycKind = K_CMD;
    endcase
  end

  assign opReady = (state == S_IDLE);
  assign wrReady = (state == S_WDATA) && !pend;
  assign writeProtectN = 1'b1;
  assign opFail = opStatus[STATUS_FAIL_BIT];

  // =====================================================
  // Operation sequencer
  // Operations run one at a time, but resume ends without waiting for ready, so the next op can reach a busy device
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= OP_READ_MAIN;
      addr <= 22'h0;
      len <= '0;
      addrIdx <= 2'd0;
      col <= 10'h000;
      pend <= 1'b0;
      chipEnableN <= 1'b1;
      spareEnableN <= 1'b1;
      opDone <= 1'b0;
      opRefused <= 1'b0;
      opStatus <= STATUS_RESET;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      progPage <= 13'h0;
      progCount <= 4'h0;
    end else begin
      opDone <= 1'b0;
      opRefused <= 1'b0;
      rdValid <= 1'b0;
      if (cycStart) begin
        pend <= 1'b1;
      end else if (cycDone) begin
        pend <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (opValid && overLimit) begin
            opRefused <= 1'b1;
          end else if (opValid) begin
            op <= opCode;
            addr <= opAddr;
            len <= opLen;
            chipEnableN <= 1'b0;
            spareEnableN <= !(spareEn || (opCode == OP_READ_SPARE));
            state <= S_CMD;
            if (opCode == OP_PROGRAM) begin
              progPage <= opAddr[21:9];
              progCount <= samePage ? progCount + 4'h1 : 4'h1;
            end else if ((opCode == OP_ERASE) && (opAddr[21:13] == progPage[12:4])) begin
              progCount <= 4'h0;
            end
          end
        end
        S_CMD: begin
          if (cycDone) begin
            addrIdx <= addrStart;
            col <= startCol;
            if (op == OP_STATUS) begin
              len <= LEN_W'(1);
              state <= S_RDATA;
            end else if ((op == OP_RESET) || (op == OP_SUSPEND)) begin
              state <= S_WAIT;
            end else if (op == OP_RESUME) begin
              state <= S_DONE;
            end else begin
              state <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (cycDone) begin
            addrIdx <= addrIdx + 2'd1;
            if (addrIdx == addrLast) begin
              if (op == OP_READ_ID) begin
                len <= LEN_W'(2);
                state <= S_RDATA;
              end else if (op == OP_ERASE) begin
                state <= S_CONF;
              end else if (op == OP_PROGRAM) begin
                // A confirm without loaded data would do nothing, so skip it
                state <= (len == '0) ? S_DONE : S_WDATA;
              end else begin
                state <= S_WAIT;
              end
            end
          end
        end
        S_WDATA: begin
          if (cycDone) begin
            len <= len - 1'b1;
            if (len == 10'd1) begin
              state <= S_CONF;
            end
          end
        end
        S_CONF: begin
          if (cycDone) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (cycDone) begin
            if (isRead) begin
              state <= (len == '0) ? S_DONE : S_RDATA;
            end else if (op == OP_RESET) begin
              opStatus <= STATUS_RESET;
              state <= S_DONE;
            end else begin
              state <= S_SCMD;
            end
          end
        end
        S_RDATA: begin
          if (cycDone) begin
            rdData <= cycData;
            rdValid <= 1'b1;
            len <= len - 1'b1;
            col <= col + 10'h001;
            if (op == OP_STATUS) begin
              opStatus <= cycData;
            end
            if (len == 10'd1) begin
              state <= S_DONE;
            end else if (isRead && (col == lastCol)) begin
              col <= wrapCol;
              state <= S_WAIT;
            end
          end
        end
        S_SCMD: begin
          if (cycDone) begin
            state <= S_SREAD;
          end
        end
        S_SREAD: begin
          if (cycDone) begin
            opStatus <= cycData;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          // Raising chip enable ends any sequential read in progress
          chipEnableN <= 1'b1;
          opDone <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // =====================================================
  // Pin cycle engine
  npc_pin_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .cycStart(cycStart),
    .cycKind(cycKind),
    .cycByte(cycByte),
    .cycDone(cycDone),
    .cycData(cycData),
    .ioIn(ioIn),
    .ioOut(ioOut),
    .ioOeN(ioOeN),
    .cmdLatch(cmdLatch),
    .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN),
    .readyBusyN(readyBusyN)
  );

endmodule

// ==== tb/npc_host_chk.sv ====
`timescale 1ns/1ps
// ==========
// Pin-level checks on the host
module npc_host_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic opRefused,
  input wire logic [7:0] opStatus,
  input wire logic opFail,
  input wire logic ioOeN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic chipEnableN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_LATCH_EXCL: assert property (!(cmdLatch && addrLatch)) else $error("both latches high");
  AST_STROBE_EXCL: assert property (writeStrobeN || readStrobeN) else $error("both strobes low");
  AST_WE_DRIVES: assert property (!writeStrobeN |-> !ioOeN && !chipEnableN) else $error("write off bus");
  AST_WE_SHAPE: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*4] ##1 writeStrobeN [*2])
    else $error("write strobe shape");
  AST_WAIT_READ: assert property ($rose(writeStrobeN) |-> readStrobeN [*6]) else $error("read too soon");
  AST_REFUSE_QUIET: assert property (opRefused |-> chipEnableN && writeStrobeN) else $error("pins moved");
  AST_RESET_STATUS: assert property ($rose(rst_n) |-> opStatus == 8'hC0) else $error("status after reset");
  AST_FAIL_BIT: assert property (opFail == opStatus[0]) else $error("fail bit");
  AST_CE_FRAME: assert property (chipEnableN |-> writeStrobeN && readStrobeN && !cmdLatch && !addrLatch)
    else $error("strobe outside frame");
endmodule

bind npc_host npc_host_chk u_chk (.clk, .rst_n, .opRefused, .opStatus, .opFail, .ioOeN, .cmdLatch, .addrLatch,
  .chipEnableN, .writeStrobeN, .readStrobeN);

// ==== tb/npc_flash_model.sv ====
`timescale 1ns/1ps
// ==========
// Behavioural flash device
module npc_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary value
) (
  // Delay base and test controls
  input wire logic clk,
  input wire logic slow,
  input wire logic failNext,
  // Flash pins
  input wire logic [7:0] ioOut,
  input wire logic ioOeN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic chipEnableN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic spareEnableN,
  input wire logic writeProtectN,
  output logic [7:0] ioIn,
  output logic readyBusyN
);
  logic [1:0] mode = 2'h0, ptr = 2'h0, op = 2'h0, aCnt = 2'h0;
  logic [9:0] col = 10'h0;
  logic [12:0] page = 13'h0;
  logic [11:0] busy = 12'h0;
  logic fail = 0, susp = 0, loaded = 0, idIdx = 0, prevWe = 1, prevRe = 1;
  logic [7:0] hold = 8'h0;
  wire weRise = writeStrobeN && !prevWe && !chipEnableN;
  wire reRise = readStrobeN && !prevRe && !chipEnableN;
  wire [9:0] last = (ptr == 2'h2 || !spareEnableN) ? 10'h20F : 10'h1FF;
  wire [7:0] stat = {writeProtectN, busy == 12'h0, susp, 4'h0, fail};
  wire [7:0] data = page[7:0] ^ col[7:0] ^ {{4{col[9]}}, {4{col[8]}}};
  // Page register unusable while a page loads, so an early read shows wrong data
  wire [7:0] pageB = (busy != 12'h0) ? ~data : data;
  wire [7:0] outB = (mode == 2'h1) ? stat : (mode == 2'h2) ? (idIdx ? PART_ID : MAKER_ID) : pageB;
  wire [11:0] dly = slow ? 12'h12C : 12'h014;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign ioIn = !ioOeN ? ioOut : (!readStrobeN && !chipEnableN) ? outB : ~hold;
  assign readyBusyN = (busy == 12'h0);
  always @(posedge clk) begin
    prevWe <= writeStrobeN;
    prevRe <= readStrobeN;
    if (!readStrobeN) hold <= outB;
    if (busy != 12'h0) busy <= busy - 12'h1;
    if (weRise && cmdLatch && (op != 2'h1 || busy == 12'h0 || ioOut == 8'h70 || ioOut == 8'hFF)) begin
      aCnt <= 2'h0;
      case (ioOut)
        8'h00, 8'h01, 8'h50: begin
          mode <= 2'h0;
          op <= 2'h0;
          ptr <= ioOut[6] ? 2'h2 : ioOut[1:0];
        end
        8'h80: op <= 2'h1;
        8'h10: if (op == 2'h1 && loaded) begin
          busy <= dly;
          fail <= failNext;
          loaded <= 0;
        end
        8'h60: op <= 2'h2;
        8'hD0: if (susp || op == 2'h2) begin
          busy <= dly * 4;
          susp <= 0;
          fail <= 0;
        end
        8'hB0: if (op == 2'h2 && busy != 12'h0) begin
          busy <= 12'h0;
          susp <= 1;
        end
        8'h70: mode <= 2'h1;
        8'h90: begin
          mode <= 2'h2;
          idIdx <= 0;
        end
        8'hFF: if (!(op == 2'h3 && busy != 12'h0)) begin
          op <= 2'h3;
          busy <= dly;
          {mode, ptr, col, page, fail, susp, loaded} <= '0;
        end
        default: ;
      endcase
    end else if (weRise && addrLatch) begin
      aCnt <= aCnt + 2'h1;
      if (op == 2'h2 && aCnt == 2'h0) page[7:0] <= ioOut;
      else if (op == 2'h2) page[12:8] <= ioOut[4:0];
      else if (aCnt == 2'h0) col <= (ptr == 2'h2) ? {6'h20, ioOut[3:0]} : {1'b0, ptr[0], ioOut};
      else if (aCnt == 2'h1) page[7:0] <= ioOut;
      else begin
        page[12:8] <= ioOut[4:0];
        if (op == 2'h0 && mode == 2'h0) busy <= dly;
        if (ptr == 2'h1) ptr <= 2'h0;
      end
    end else if (weRise && op == 2'h1) loaded <= 1;
    if (reRise && mode == 2'h2) idIdx <= 1;
    if (reRise && mode == 2'h0) begin
      col <= (col == last) ? ((ptr == 2'h2) ? 10'h200 : 10'h0) : col + 10'h1;
      if (col == last) page <= page + 13'h1;
      if (col == last) busy <= dly;
    end
  end
endmodule

// ==== tb/nand_page_command_engine_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module nand_page_command_engine_tb;
  import npc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] PART = 8'hA5; // Arbitrary value
  logic clk = 0, rst_n = 0, opValid = 0, spareEn = 0, wrValid = 0, slow = 0, failNext = 0;
  npc_op_t opCode = OP_STATUS;
  logic [21:0] opAddr = 0;
  logic [9:0] opLen = 0;
  logic [7:0] wrData = 0;
  wire opReady, opDone, opRefused, opFail, wrReady, rdValid, ioOeN, cmdLatch, addrLatch, chipEnableN;
  wire writeStrobeN, readStrobeN, spareEnableN, writeProtectN, readyBusyN;
  wire [7:0] opStatus, rdData, ioIn, ioOut;
  int err_count = 0, check_count = 0, seed = 72, refCnt = 0;
  logic endSeen = 0;
  logic [7:0] rdq[$];
  npc_host uut (.clk, .rst_n, .opValid, .opReady, .opCode, .opAddr, .opLen, .spareEn, .opDone, .opRefused,
    .opStatus, .opFail, .wrData, .wrValid, .wrReady, .rdData, .rdValid, .ioIn, .ioOut, .ioOeN, .cmdLatch,
    .addrLatch, .chipEnableN, .writeStrobeN, .readStrobeN, .spareEnableN, .writeProtectN, .readyBusyN);
  npc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.clk, .slow, .failNext, .ioOut, .ioOeN, .cmdLatch,
    .addrLatch, .chipEnableN, .writeStrobeN, .readStrobeN, .spareEnableN, .writeProtectN, .ioIn, .readyBusyN);
  always #5 clk = ~clk;
  always @(negedge clk) wrData <= 8'($random(seed));
  always @(posedge clk) begin
    if (rdValid) rdq.push_back(rdData);
    if (opDone || opRefused) endSeen = 1;
    if (opRefused) refCnt++;
  end
  // ==========
  // Closing and bus tasks
  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task automatic do_op(input npc_op_t c, input logic [21:0] a, input logic [9:0] n, input logic s);
    int t;
    begin
      @(negedge clk);
      opCode = c;
      opAddr = a;
      opLen = n;
      spareEn = s;
      opValid = 1;
      rdq.delete();
      endSeen = 0;
      while (opReady !== 1'b1) @(negedge clk);
      @(negedge clk);
      opValid = 0;
      t = 0;
      // Bounded wait, reads may cross a slow page load
      while (!endSeen && t < 5000) begin
        @(negedge clk);
        t++;
      end
      `CHK("op end", 1'b1, endSeen)
    end
  endtask
  function automatic logic [7:0] exp_byte(input logic [12:0] pg, input logic [9:0] col);
    return pg[7:0] ^ col[7:0] ^ {{4{col[9]}}, {4{col[8]}}};
  endfunction
  task automatic chk_read(input npc_op_t c, input logic [21:0] a, input logic [9:0] n, input logic s);
    logic [9:0] col;
    logic [9:0] last;
    logic [12:0] pg;
    begin
      do_op(c, a, n, s);
      pg = a[21:9];
      col = (c == OP_READ_SPARE) ? {6'h20, a[3:0]} : {1'b0, a[8:0]};
      last = (c == OP_READ_SPARE || s) ? 10'h20F : 10'h1FF;
      `CHK("read count", 32'(n), rdq.size())
      for (int i = 0; i < rdq.size(); i++) begin
        `CHK("read byte", exp_byte(pg, col), rdq[i])
        pg = (col == last) ? pg + 13'h1 : pg;
        col = (col != last) ? col + 10'h1 : (c == OP_READ_SPARE) ? 10'h200 : 10'h0;
      end
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    wrValid = 1;
    `CHK("reset status", 8'hC0, opStatus)
    `CHK("idle ready", 1'b1, opReady)
    do_op(OP_STATUS, 22'h0, 10'h1, 0);
    `CHK("status", 8'hC0, opStatus)
    do_op(OP_READ_ID, 22'h0, 10'h2, 0);
    `CHK("maker id", MAKER, rdq[0])
    `CHK("part id", PART, rdq[1])
    $display("test status and id done");
    chk_read(OP_READ_MAIN, {13'h0005, 9'h1FD}, 10'h6, 0);
    chk_read(OP_READ_MAIN, {13'h1FFF, 9'h1FF}, 10'h14, 1);
    chk_read(OP_READ_SPARE, {13'h0007, 9'h0FE}, 10'h4, 0);
    chk_read(OP_READ_MAIN, {13'h0009, 9'h000}, 10'h3, 0);
    repeat (16) begin
      slow = 1'($random(seed));
      chk_read(($random(seed) & 1) ? OP_READ_SPARE : OP_READ_MAIN, 22'($random(seed)),
        10'(($random(seed) & 31) + 1), 1'($random(seed)));
    end
    slow = 0;
    $display("test reads done");
    do_op(OP_PROGRAM, {13'h0040, 9'h010}, 10'h4, 0);
    `CHK("program status", 8'hC0, opStatus)
    failNext = 1;
    do_op(OP_PROGRAM, {13'h0041, 9'h000}, 10'h1, 0);
    `CHK("program fail", 1'b1, opFail)
    do_op(OP_PROGRAM, {13'h0042, 9'h000}, 10'h0, 0);
    `CHK("bare program", 1'b1, opFail)
    failNext = 0;
    do_op(OP_RESET, 22'h0, 10'h1, 0);
    `CHK("reset op status", 8'hC0, opStatus)
    chk_read(OP_READ_MAIN, {13'h0002, 9'h000}, 10'h2, 0);
    $display("test program and reset done");
    refCnt = 0;
    repeat (11) do_op(OP_PROGRAM, {13'h0080, 9'h020}, 10'h2, 0);
    `CHK("refused", 1, refCnt)
    do_op(OP_ERASE, {13'h0080, 9'h000}, 10'h1, 0);
    `CHK("erase status", 8'hC0, opStatus)
    do_op(OP_PROGRAM, {13'h0080, 9'h020}, 10'h2, 0);
    `CHK("after erase", 1, refCnt)
    do_op(OP_SUSPEND, 22'h0, 10'h1, 0);
    do_op(OP_RESUME, 22'h0, 10'h1, 0);
    do_op(OP_STATUS, 22'h0, 10'h1, 0);
    `CHK("suspend bit", 1'b0, opStatus[5])
    $display("test erase done");
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
